// ---- pkg/pew_pkg.sv ----
// Purpose: shared constants for the parallel eeprom host controller
// Assumes: 200 MHz system clock, asynchronous byte-wide eeprom on the far side
// Notes:   times are kept in their own units; cycle counts derive from them
`default_nettype none
package pew_pkg;
   localparam int          CLK_MHZ          = 200;
   localparam int          ADDR_W           = 13;
   localparam int          DATA_W           = 8;
   localparam int          PAGE_BYTES       = 64;
   localparam int          PAGE_LSB         = 6;   // first bit of page_address_bits
   // byte_load_window, longest gap between bytes, in microseconds
   localparam int          BYTE_LOAD_US     = 150;
   // internal_write_time, worst case, in milliseconds
   localparam int          WRITE_TIME_MS    = 2;
   // host keeps a safe margin under the window: a third of it
   localparam int          BYTE_LOAD_CYC    = (BYTE_LOAD_US * CLK_MHZ) / 3;
   localparam int          WRITE_TIME_CYC   = WRITE_TIME_MS * 1000 * CLK_MHZ;
   // strobe timing: write pulse 100 ns low, 50 ns high, read access 120 ns
   localparam int          STROBE_NS        = 100;
   localparam int          STROBE_CYC       = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int          SETUP_CYC        = 2;
   localparam int          READ_NS          = 120;
   localparam int          READ_CYC         = (READ_NS * CLK_MHZ + 999) / 1000 + 1;
   localparam int          CNT_W            = 24;
   // three-byte lock-on and six-byte lock-off commands: fixed addresses and data
   localparam logic [12:0] LOCK_ADDR0       = 13'h1555;
   localparam logic [12:0] LOCK_ADDR1       = 13'h0aaa;
   localparam logic [7:0]  LOCK_DATA0       = 8'haa;
   localparam logic [7:0]  LOCK_DATA1       = 8'h55;
   localparam logic [7:0]  LOCK_ON_DATA     = 8'ha0;
   localparam logic [7:0]  LOCK_OFF_DATA    = 8'h80;
   localparam logic [7:0]  LOCK_OFF_DATA1   = 8'h20;
   typedef enum logic [1:0] {PEW_OP_READ, PEW_OP_PAGE, PEW_OP_LOCK_ON,
                             PEW_OP_LOCK_OFF} pew_op_e;
endpackage : pew_pkg
`default_nettype wire

// ---- verilog/pew_strobe.sv ----
// Purpose: drives one write strobe pulse or one read cycle on the eeprom pins
// Assumes: caller holds address and data steady while busy
// Notes:   write enable pulses low for STROBE_CYC + 1 cycles with output enable high
`default_nettype none
module pew_strobe (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // command
   input  wire logic        go,
   input  wire logic        is_read,
   output logic             done,
   // pins
   output logic             we_n,
   output logic             oe_n,
   output logic             drive
);
   import pew_pkg::*;
   typedef enum logic [1:0] {PEW_S_IDLE, PEW_S_SETUP, PEW_S_PULSE, PEW_S_HOLD} pew_sst_e;
   pew_sst_e   st_reg, st_next;
   logic [7:0] cnt_reg, cnt_next;
   logic       rd_reg, rd_next;

   // sequence: setup, strobe low, release with data still held
   always_comb begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      rd_next  = rd_reg;
      done     = 1'b0;
      unique case (st_reg)
         PEW_S_IDLE: begin
            if (go) begin
               st_next  = PEW_S_SETUP;
               rd_next  = is_read;
               cnt_next = 8'(SETUP_CYC);
            end
         end
         PEW_S_SETUP: begin
            if (cnt_reg == 8'h00) begin
               st_next  = PEW_S_PULSE;
               cnt_next = rd_reg ? 8'(READ_CYC) : 8'(STROBE_CYC);
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         PEW_S_PULSE: begin
            if (cnt_reg == 8'h00) begin
               st_next  = PEW_S_HOLD;
               cnt_next = 8'(STROBE_CYC);  // also covers the high-pulse minimum
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         PEW_S_HOLD: begin
            // a go raised together with done starts the next cycle at once, so a
            // caller chaining bytes never loses its request to the idle state
            if (cnt_reg == 8'h00) begin
               done = 1'b1;
               if (go) begin
                  st_next  = PEW_S_SETUP;
                  rd_next  = is_read;
                  cnt_next = 8'(SETUP_CYC);
               end else begin
                  st_next = PEW_S_IDLE;
               end
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg  <= PEW_S_IDLE;
         cnt_reg <= 8'h00;
         rd_reg  <= 1'b0;
      end else begin
         st_reg  <= st_next;
         cnt_reg <= cnt_next;
         rd_reg  <= rd_next;
      end
   end

   // output enable only low on a read, never together with write strobe
   assign we_n  = ~((st_reg == PEW_S_PULSE) && !rd_reg);
   assign oe_n  = ~((st_reg == PEW_S_PULSE) && rd_reg);
   assign drive = (st_reg != PEW_S_IDLE) && !rd_reg;
endmodule : pew_strobe
`default_nettype wire

// ---- verilog/pew_host.sv ----
// Purpose: host controller for a byte-wide parallel eeprom: reads, page loads, lock commands
// Assumes: device pins are asynchronous; inputs are synchronous to sys_clk
// Notes:   one request at a time; pages are loaded from a local 64-byte buffer
// Functional notes
// - Host keeps page_address_bits identical on every strobe of a page load.
// - Host keeps output-enable high while write strobe and chip-select are low.
// - Next byte within byte_load_window; device programs within internal_write_time.
// - A page write carries one to sixty-four data bytes.
// - While locked, each write is preceded by the three-byte enable command; the host sends it only when req_locked comes with the request.
`default_nettype none
module pew_host #(
   parameter int WRITE_WAIT_CYC = pew_pkg::WRITE_TIME_CYC,
   parameter int LOAD_GAP_CYC   = pew_pkg::BYTE_LOAD_CYC
) (
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        resetn,
   // request from user
   input  wire logic                        req_valid,
   output logic                             req_ready,
   input  wire pew_pkg::pew_op_e            req_op,
   input  wire logic [pew_pkg::ADDR_W-1:0]  req_addr,
   input  wire logic [6:0]                  req_len,
   input  wire logic                        req_locked,
   // page buffer fill
   input  wire logic                        wbuf_we,
   input  wire logic [5:0]                  wbuf_idx,
   input  wire logic [pew_pkg::DATA_W-1:0]  wbuf_data,
   // answer
   output logic                             rsp_valid,
   output logic [pew_pkg::DATA_W-1:0]       rsp_data,
   // eeprom pins
   output logic [pew_pkg::ADDR_W-1:0]       mem_addr,
   output logic                             mem_ce_n,
   output logic                             mem_oe_n,
   output logic                             mem_we_n,
   input  wire logic [pew_pkg::DATA_W-1:0]  data_lines_in,
   output logic [pew_pkg::DATA_W-1:0]       data_lines_out,
   output logic                             data_lines_oe_n
);
   import pew_pkg::*;
   typedef enum logic [2:0] {PEW_IDLE, PEW_CMD, PEW_LOAD, PEW_GAP, PEW_READ,
                             PEW_WAIT} pew_st_e;

   logic [DATA_W-1:0] page_mem [PAGE_BYTES];   // user bytes for the next page
   pew_st_e           st_reg, st_next;
   pew_op_e           op_reg, op_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] dout_reg, dout_next;
   logic [DATA_W-1:0] rdat_reg, rdat_next;
   logic [6:0]        len_reg, len_next;
   logic [6:0]        idx_reg, idx_next;
   logic [2:0]        cmd_reg, cmd_next;
   logic              pre_reg, pre_next;
   logic              rsp_reg, rsp_next;
   logic [CNT_W-1:0]  tmr_reg, tmr_next;
   logic              sgo, srd, sdone, swe_n, soe_n, sdrive;
   logic [ADDR_W-PAGE_LSB-1:0] rpage_reg;   // page field of the pending request

   // command byte k of a lock sequence; k==3 and k==4 are the extra off pair
   function automatic logic [20:0] cmd_word(input logic [2:0] k, input pew_op_e op);
      logic [20:0] w;
      w = {LOCK_ADDR0, LOCK_DATA0};
      unique case (k)
         3'd0: w = {LOCK_ADDR0, LOCK_DATA0};
         3'd1: w = {LOCK_ADDR1, LOCK_DATA1};
         3'd2: w = {LOCK_ADDR0, (op == PEW_OP_LOCK_OFF) ? LOCK_OFF_DATA : LOCK_ON_DATA};
         3'd3: w = {LOCK_ADDR0, LOCK_DATA0};
         3'd4: w = {LOCK_ADDR1, LOCK_DATA1};
         default: w = {LOCK_ADDR0, LOCK_OFF_DATA1};
      endcase
      return w;
   endfunction : cmd_word

   // last command index: two for enable, five for disable
   function automatic logic [2:0] cmd_last(input pew_op_e op);
      return (op == PEW_OP_LOCK_OFF) ? 3'd5 : 3'd2;
   endfunction : cmd_last

   // page buffer write port
   always_ff @(posedge sys_clk) begin
      if (wbuf_we) begin
         page_mem[wbuf_idx] <= wbuf_data;
      end
   end

   pew_strobe u_strobe (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .go      (sgo),
      .is_read (srd),
      .done    (sdone),
      .we_n    (swe_n),
      .oe_n    (soe_n),
      .drive   (sdrive)
   );

   // main sequencer
   always_comb begin
      st_next   = st_reg;
      op_next   = op_reg;
      addr_next = addr_reg;
      dout_next = dout_reg;
      len_next  = len_reg;
      idx_next  = idx_reg;
      cmd_next  = cmd_reg;
      pre_next  = pre_reg;
      rsp_next  = 1'b0;
      tmr_next  = (tmr_reg != '0) ? tmr_reg - 1'b1 : tmr_reg;
      sgo       = 1'b0;
      srd       = 1'b0;
      unique case (st_reg)
         PEW_IDLE: begin
            // a new load waits out the previous programming time
            if (req_valid && tmr_reg == '0) begin
               op_next  = req_op;
               addr_next = req_addr;
               len_next = (req_len == 7'h00) ? 7'h01 :
                          (req_len > 7'(PAGE_BYTES)) ? 7'(PAGE_BYTES) : req_len;
               idx_next = 7'h00;
               cmd_next = 3'd0;
               pre_next = (req_op == PEW_OP_PAGE) && req_locked;
               if (req_op == PEW_OP_READ) begin
                  st_next = PEW_READ;
                  sgo     = 1'b1;
                  srd     = 1'b1;
               end else if (req_op == PEW_OP_PAGE && !req_locked) begin
                  st_next   = PEW_LOAD;
                  dout_next = page_mem[6'h00];
                  addr_next = {req_addr[ADDR_W-1:PAGE_LSB], 6'h00};
                  sgo       = 1'b1;
               end else begin
                  st_next = PEW_CMD;
                  {addr_next, dout_next} = cmd_word(3'd0, req_op);
                  sgo     = 1'b1;
               end
            end
         end
         PEW_CMD: begin
            if (sdone) begin
               tmr_next = CNT_W'(LOAD_GAP_CYC);
               if (cmd_reg == (pre_reg ? 3'd2 : cmd_last(op_reg))) begin
                  if (op_reg == PEW_OP_PAGE) begin
                     st_next   = PEW_LOAD;
                     addr_next = {rpage_reg, 6'h00};
                     dout_next = page_mem[6'h00];
                     sgo       = 1'b1;
                  end else begin
                     // lock state changes at end of write with no data loaded
                     st_next  = PEW_WAIT;
                     // device programs only after its load window runs out
                     tmr_next = CNT_W'(WRITE_WAIT_CYC) + CNT_W'(LOAD_GAP_CYC * 3);
                  end
               end else begin
                  cmd_next = cmd_reg + 3'd1;
                  {addr_next, dout_next} = cmd_word(cmd_reg + 3'd1, op_reg);
                  sgo      = 1'b1;
               end
            end
         end
         PEW_LOAD: begin
            if (sdone) begin
               idx_next = idx_reg + 7'h01;
               if (idx_reg + 7'h01 >= len_reg) begin
                  // stop loading; device starts programming after the window
                  st_next  = PEW_WAIT;
                  tmr_next = CNT_W'(WRITE_WAIT_CYC) + CNT_W'(LOAD_GAP_CYC * 3);
               end else begin
                  // same page field, only the low bits advance
                  addr_next = {addr_reg[ADDR_W-1:PAGE_LSB], 6'(idx_reg + 7'h01)};
                  dout_next = page_mem[6'(idx_reg + 7'h01)];
                  sgo       = 1'b1;
               end
            end
         end
         PEW_READ: begin
            if (sdone) begin
               rsp_next = 1'b1;
               st_next  = PEW_IDLE;
            end
         end
         PEW_WAIT: begin
            st_next = PEW_IDLE;  // idle itself holds off until the timer runs out
         end
         default: st_next = PEW_IDLE;
      endcase
   end

   // capture read data while output enable is low at the end of access
   always_comb begin
      rdat_next = rdat_reg;
      if (!soe_n && sdone == 1'b0) begin
         rdat_next = data_lines_in;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg    <= PEW_IDLE;
         op_reg    <= PEW_OP_READ;
         addr_reg  <= '0;
         dout_reg  <= '0;
         rdat_reg  <= '0;
         len_reg   <= 7'h00;
         idx_reg   <= 7'h00;
         cmd_reg   <= 3'd0;
         pre_reg   <= 1'b0;
         rsp_reg   <= 1'b0;
         tmr_reg   <= '0;
         rpage_reg <= '0;
      end else begin
         st_reg    <= st_next;
         op_reg    <= op_next;
         addr_reg  <= addr_next;
         dout_reg  <= dout_next;
         rdat_reg  <= rdat_next;
         len_reg   <= len_next;
         idx_reg   <= idx_next;
         cmd_reg   <= cmd_next;
         pre_reg   <= pre_next;
         rsp_reg   <= rsp_next;
         tmr_reg   <= tmr_next;
         rpage_reg <= (st_reg == PEW_IDLE) ? req_addr[ADDR_W-1:PAGE_LSB] : rpage_reg;
      end
   end

   // pin drive: chip-select follows any strobe activity
   assign req_ready       = (st_reg == PEW_IDLE) && (tmr_reg == '0);
   assign rsp_valid       = rsp_reg;
   assign rsp_data        = rdat_reg;
   assign mem_addr        = addr_reg;
   assign mem_ce_n        = swe_n & soe_n;
   assign mem_we_n        = swe_n;
   assign mem_oe_n        = soe_n;
   assign data_lines_out  = dout_reg;
   assign data_lines_oe_n = ~sdrive;   // low while host drives the data lines
endmodule : pew_host
`default_nettype wire

// ---- sim/pew_host_checker.sv ----
// Purpose: pin and answer checks on the eeprom host controller
// Assumes: sees only the pew_host ports; a single clock domain
// Notes:   gap limits scale with the same parameters the design gets
`default_nettype none
module pew_host_checker #(
   parameter int WRITE_WAIT_CYC = 400,
   parameter int LOAD_GAP_CYC   = 20
) (
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        resetn,
   // user side
   input  wire logic                        req_ready,
   input  wire logic                        rsp_valid,
   // eeprom pins
   input  wire logic [pew_pkg::ADDR_W-1:0]  mem_addr,
   input  wire logic                        mem_ce_n,
   input  wire logic                        mem_oe_n,
   input  wire logic                        mem_we_n,
   input  wire logic                        data_lines_oe_n
);
   import pew_pkg::*;
   logic [23:0] gap_reg;
   logic [23:0] gap_next;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // cycles since the last strobe ended, saturating so idle time never wraps
   always_comb begin
      gap_next = gap_reg;
      if (!mem_we_n) gap_next = 24'h000000;
      else if (gap_reg != 24'hffffff) gap_next = gap_reg + 24'h000001;
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) gap_reg <= 24'hffffff;
      else gap_reg <= gap_next;
   end
   a_oe_high_write: assert property (!mem_we_n && !mem_ce_n |-> mem_oe_n)
      else $error("output enable low during a write strobe");
   a_data_on_write: assert property (!mem_we_n && !mem_ce_n |-> !data_lines_oe_n)
      else $error("data lines not driven during a write strobe");
   a_no_contention: assert property (!mem_oe_n |-> data_lines_oe_n)
      else $error("host drives data while device output is enabled");
   a_read_strobes: assert property (!mem_oe_n |-> !mem_ce_n && mem_we_n)
      else $error("read without chip select or with write strobe low");
   a_read_answer: assert property ($fell(mem_oe_n) |-> ##[1:80] rsp_valid)
      else $error("read answer missing after output enable");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("read answer longer than one cycle");
   a_addr_steady: assert property (!mem_we_n ##1 !mem_we_n |-> $stable(mem_addr))
      else $error("address moved while the write strobe was low");
   a_pulse_width: assert property ($fell(mem_we_n) |-> !mem_we_n [*8])
      else $error("write strobe too short");
   a_byte_gap: assert property ($fell(mem_we_n) |-> gap_reg <= 3 * LOAD_GAP_CYC
      || gap_reg >= WRITE_WAIT_CYC - 2 * STROBE_CYC)
      else $error("byte gap outside the load window yet under the write time");
   a_busy_after: assert property ($rose(mem_we_n) |-> !req_ready)
      else $error("ready while a write is still in progress");
endmodule : pew_host_checker
bind pew_host pew_host_checker #(
   .WRITE_WAIT_CYC(WRITE_WAIT_CYC),
   .LOAD_GAP_CYC  (LOAD_GAP_CYC)
) i_pew_host_checker (
   .sys_clk(sys_clk), .resetn(resetn), .req_ready(req_ready), .rsp_valid(rsp_valid),
   .mem_addr(mem_addr), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
   .data_lines_oe_n(data_lines_oe_n)
);
`default_nettype wire

// ---- sim/pew_mem_model.sv ----
// Purpose: behavioural byte-wide eeprom with page latch and write lock
// Assumes: sys_clk samples the strobes and times the load window and programming period
// Notes:   a released wire shows a changing pattern, never the last value
`default_nettype none
module pew_mem_model #(
   parameter int WIN_CYC  = 100,
   parameter int PROG_CYC = 200
) (
   // timer clock
   input  wire logic        sys_clk,
   // device pins
   input  wire logic [12:0] addr,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   // data wire
   input  wire logic [7:0]  host_d,
   input  wire logic        host_oe_n,
   output logic [7:0]       bus,
   output logic             viol
);
   import pew_pkg::*;
   logic [7:0]  mem [0:8191];
   logic [20:0] q [$];
   logic [7:0]  last;
   logic        we_d;
   logic        lock;
   int          idle;
   int          busy;
   initial begin
      lock = 1'b0;
      viol = 1'b0;
      we_d = 1'b1;
      last = 8'h00;
      busy = 0;
      idle = 0;
      foreach (mem[i]) mem[i] = 8'hff;
   end
   // wire level from both drivers
   always_comb begin
      if (!ce_n && !oe_n && we_n) bus = mem[addr];
      else if (!host_oe_n) bus = host_d;
      else bus = ~last;
   end
   // end of load: strip lock commands, then store the user bytes if unlocked or led by the enable command
   task automatic commit();
      int k;
      logic lk;
      k = 0;
      lk = lock;
      if (q.size() >= 6 && q[0][7:0] == LOCK_DATA0 && q[2][7:0] == LOCK_OFF_DATA
          && q[5][7:0] == LOCK_OFF_DATA1) begin
         k = 6;
         lk = 1'b0;
      end else if (q.size() >= 3 && q[0] == {LOCK_ADDR0, LOCK_DATA0}
          && q[1] == {LOCK_ADDR1, LOCK_DATA1} && q[2] == {LOCK_ADDR0, LOCK_ON_DATA}) begin
         k = 3;
         lk = 1'b1;
      end
      if (q.size() - k > 64) viol = 1'b1;
      for (int i = k; i < q.size(); i++) begin
         if (q[i][20:14] != q[k][20:14]) viol = 1'b1;
         if (!lock || k == 3) mem[q[i][20:8]] = q[i][7:0];
      end
      lock = lk;
      q.delete();
      busy = PROG_CYC;
   endtask : commit
   // byte latch on the strobe's rising edge, window and programming timers
   always @(posedge sys_clk) begin
      last <= bus;
      if (!we_n && !ce_n && !oe_n) viol = 1'b1;
      if (!ce_n && !oe_n && !host_oe_n) viol = 1'b1;
      if (busy > 0) busy--;
      // chip-select rises with the write strobe, so the pair is one strobe
      if (!we_d && (we_n | ce_n) && oe_n) begin
         if (busy > 0) viol = 1'b1;
         q.push_back({addr, bus});
         idle = 0;
      end else if (q.size() > 0 && ++idle >= WIN_CYC) commit();
      we_d = we_n | ce_n;
   end
endmodule : pew_mem_model
`default_nettype wire

// ---- sim/parallel_eeprom_page_write_tb.sv ----
// Purpose: self-checking bench for the eeprom host controller
// Assumes: write and load times shortened through the parameters
// Notes:   a shadow copy of the array gives the expected read value of every table row
`default_nettype none
module parallel_eeprom_page_write_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import pew_pkg::*;
   typedef struct packed {
      pew_op_e op; logic [12:0] addr; logic [6:0] len; logic locked; logic [12:0] chk;
   } pew_row_s;
   // op, address, length, locked, address read back afterwards
   localparam pew_row_s ROWS [0:7] = '{
      '{PEW_OP_PAGE, 13'h0140, 7'h50, 1'b0, 13'h017f}, '{PEW_OP_PAGE, 13'h0200, 7'h01, 1'b0, 13'h0200},
      '{PEW_OP_PAGE, 13'h0240, 7'h00, 1'b0, 13'h0240}, '{PEW_OP_LOCK_ON, 13'h0000, 7'h01, 1'b0, 13'h0140},
      '{PEW_OP_PAGE, 13'h0140, 7'h02, 1'b0, 13'h0140}, '{PEW_OP_PAGE, 13'h0140, 7'h02, 1'b1, 13'h0141},
      '{PEW_OP_LOCK_OFF, 13'h0000, 7'h01, 1'b1, 13'h0200}, '{PEW_OP_PAGE, 13'h1fc0, 7'h03, 1'b0, 13'h1fc2}};
   logic sys_clk, resetn, req_valid, req_ready, req_locked, wbuf_we, rsp_valid;
   logic mem_ce_n, mem_oe_n, mem_we_n, data_lines_oe_n, viol, lock, seen;
   pew_op_e     req_op;
   logic [12:0] req_addr, mem_addr;
   logic [6:0]  req_len;
   logic [5:0]  wbuf_idx;
   logic [7:0]  wbuf_data, rsp_data, data_lines_out, bus_level;
   logic [7:0]  shadow [0:8191];
   int          num_errors = 0;
   int          checked = 0;
   int          n;
   pew_host #(.WRITE_WAIT_CYC(400), .LOAD_GAP_CYC(20)) i_pew_host (
      .sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
      .req_op(req_op), .req_addr(req_addr), .req_len(req_len), .req_locked(req_locked),
      .wbuf_we(wbuf_we), .wbuf_idx(wbuf_idx), .wbuf_data(wbuf_data), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
      .mem_we_n(mem_we_n), .data_lines_in(bus_level), .data_lines_out(data_lines_out),
      .data_lines_oe_n(data_lines_oe_n));
   pew_mem_model #(.WIN_CYC(100), .PROG_CYC(200)) i_pew_mem_model (
      .sys_clk(sys_clk), .addr(mem_addr), .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n),
      .host_d(data_lines_out), .host_oe_n(data_lines_oe_n), .bus(bus_level), .viol(viol));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic summarize();
      if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // request held for one clock cycle; waits for ready first
   task automatic send(input pew_op_e op, input logic [12:0] a, input logic [6:0] l,
                       input logic lk);
      int w;
      w = 0;
      @(negedge sys_clk);
      while (req_ready !== 1'b1 && w < 20000) begin @(negedge sys_clk); w++; end
      check(8'(w < 20000), 8'h01);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_op    <= op;
      {req_addr, req_len, req_locked} <= {a, l, lk};
      @(posedge sys_clk);
      req_valid <= 1'b0;
   endtask : send
   task automatic rd(input logic [12:0] a, input logic [7:0] exp);
      int w;
      w = 0;
      send(PEW_OP_READ, a, 7'h01, 1'b0);
      while (rsp_valid !== 1'b1 && w < 200) begin @(negedge sys_clk); w++; end
      check(8'(w < 200), 8'h01);
      check(rsp_data, exp);
   endtask : rd
   task automatic fill(input int r);
      for (int i = 0; i < 64; i++) begin
         @(posedge sys_clk);
         {wbuf_we, wbuf_idx, wbuf_data} <= {1'b1, 6'(i), 8'(r * 37 + i)};
      end
      @(posedge sys_clk);
      wbuf_we <= 1'b0;
   endtask : fill
   initial begin
      {resetn, req_valid, req_locked, wbuf_we, lock} = 5'h00;
      req_op = PEW_OP_READ;
      {req_addr, req_len, wbuf_idx, wbuf_data} = '0;
      foreach (shadow[i]) shadow[i] = 8'hff;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      @(negedge sys_clk);
      check({mem_ce_n, mem_we_n, mem_oe_n, data_lines_oe_n, rsp_valid, 3'h0}, 8'hf0);
      // table rows: loads, lock commands and read-back through the shadow copy
      foreach (ROWS[r]) begin
         if (ROWS[r].op == PEW_OP_PAGE) fill(r);
         send(ROWS[r].op, ROWS[r].addr, ROWS[r].len, ROWS[r].locked);
         n = ROWS[r].len == 0 ? 1 : ROWS[r].len > 64 ? 64 : int'(ROWS[r].len);
         if (ROWS[r].op == PEW_OP_PAGE && (!lock || ROWS[r].locked))
            for (int i = 0; i < n; i++) shadow[{ROWS[r].addr[12:6], 6'(i)}] = 8'(r * 37 + i);
         if (ROWS[r].op == PEW_OP_LOCK_ON) lock = 1'b1;
         if (ROWS[r].op == PEW_OP_LOCK_OFF) lock = 1'b0;
         rd(ROWS[r].chk, shadow[ROWS[r].chk]);
      end
      // a read offered while a page is in progress is not taken
      fill(9);
      send(PEW_OP_PAGE, 13'h0380, 7'h02, 1'b0);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_op    <= PEW_OP_READ;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      seen = 1'b0;
      repeat (100) begin @(negedge sys_clk); seen = seen | rsp_valid; end
      check({7'h00, seen}, 8'h00);
      rd(13'h0381, 8'(9 * 37 + 1));
      // reset in the middle of a page load returns the pins to idle
      send(PEW_OP_PAGE, 13'h03c0, 7'h40, 1'b0);
      // cut while the strobe is high: a cut low pulse would latch a stray byte
      repeat (210) @(posedge sys_clk);
      resetn <= 1'b0;
      @(negedge sys_clk);
      check({mem_ce_n, mem_we_n, mem_oe_n, data_lines_oe_n, rsp_valid, 3'h0}, 8'hf0);
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (400) @(negedge sys_clk);
      check({7'h00, viol}, 8'h00);
      summarize();
   end
   // watchdog well beyond the expected run of some 10000 cycles
   initial begin
      #300us;
      num_errors++;
      summarize();
   end
endmodule : parallel_eeprom_page_write_tb
`default_nettype wire
